// >>> src/dss_divider.sv
// Restoring serial divider, one quotient bit per clock.
// Assumes start is a pulse; a new start restarts a running division.
`timescale 1ns/100ps
`default_nettype none
module dss_divider #(
	parameter int N = 32,
	parameter int D = 20
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [N-1:0] dividend,
	input wire logic [D-1:0] divisor,
	output logic done,
	output logic [N-1:0] quotient
);
	localparam int CW = $clog2(N + 1);
	logic [D-1:0] rem;
	logic [CW-1:0] cnt;
	logic [D:0] shifted;
	logic [D:0] diff;

	assign shifted = {rem, quotient[N-1]};
	assign diff = shifted - {1'b0, divisor};

	// Shift the dividend through the remainder, subtracting where it fits.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rem <= '0;
			quotient <= '0;
			cnt <= '0;
		end
		else if (start)
		begin
			rem <= '0;
			quotient <= dividend;
			cnt <= CW'(N);
		end
		else if (cnt != '0)
		begin
			cnt <= cnt - 1'b1;
			if (shifted >= {1'b0, divisor})
			begin
				rem <= diff[D-1:0];
				quotient <= {quotient[N-2:0], 1'b1};
			end
			else
			begin
				rem <= shifted[D-1:0];
				quotient <= {quotient[N-2:0], 1'b0};
			end
		end
	end

	// One-cycle pulse when the last quotient bit has been formed.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			done <= 1'b0;
		else
			done <= !start && (cnt == CW'(1));
	end
endmodule // dss_divider
`default_nettype wire

// >>> src/dss_pkg.sv
// Shared constants, configuration carrier and state type of the stop sequencer.
// Assumes speeds in hundredths of a percent and times in tenths of a second.
package dss_pkg;

	// ------------------------------------------------------------------
	// Widths and scaling
	// ------------------------------------------------------------------
	localparam int SPD_W = 16;
	localparam int TIME_W = 16;
	localparam int MS_W = 20;
	localparam int ACC_W = 32;
	localparam int FRAC_W = 16;
	localparam logic [15:0] FULL_SCALE = 16'h2710; // 100.00 percent.
	localparam logic [15:0] ENABLE_SPLIT_THR = 16'h0019; // 0.25 percent.
	localparam logic [15:0] CUR_LIMIT_OPEN = 16'h4e20; // 200.00 percent, no cap.
	localparam logic [15:0] FRAC_ZERO = 16'h0000;
	localparam logic [19:0] MS_PER_TENTH = 20'h00064;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000 * 1000) / CLK_PERIOD_PS;

	// ------------------------------------------------------------------
	// Reset values of the settings, tenths of a second or hundredths of a percent
	// ------------------------------------------------------------------
	localparam logic [15:0] NORMAL_RAMP_DEF = 16'h0064;
	localparam logic [15:0] NORMAL_TIMEOUT_DEF = 16'h0258;
	localparam logic [15:0] HOLD_TIME_DEF = 16'h000a;
	localparam logic [15:0] FAST_RAMP_DEF = 16'h0001;
	localparam logic [15:0] FAST_TIMEOUT_DEF = 16'h0258;
	localparam logic [15:0] STOPPED_THR_DEF = 16'h00c8;
	localparam logic [15:0] FAST_CAP_DEF = 16'h2710;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic regen;
		logic [TIME_W-1:0] normal_ramp_duration;
		logic [TIME_W-1:0] normal_stop_timeout;
		logic [TIME_W-1:0] main_relay_hold_time;
		logic [TIME_W-1:0] fast_stop_ramp_duration;
		logic [TIME_W-1:0] fast_stop_timeout;
		logic [15:0] stopped_speed_threshold;
		logic [15:0] fast_stop_current_cap;
	} dss_cfg_s;

	typedef enum logic [2:0] {S_OFF, S_RUN, S_NSTOP, S_FSTOP, S_HOLD} dss_state_e;

endpackage

// >>> src/dss_stop_sequencer.sv
// Stop sequencer of a DC drive: normal stop, latched fast stop, timeouts,
// contactor hold, drive enable gating and fast stop current cap.
// Assumes all inputs are synchronous to clk_sys and settings are quasi-static.
`timescale 1ns/100ps
`default_nettype none
module dss_stop_sequencer #(
	parameter int TICK_CYCLES = dss_pkg::TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire dss_pkg::dss_cfg_s cfg,
	input wire logic run_input_terminal,
	input wire logic fast_stop_input_terminal,
	input wire logic enable_input_terminal,
	input wire logic signed [dss_pkg::SPD_W-1:0] speed_setpoint,
	input wire logic signed [dss_pkg::SPD_W-1:0] speed_feedback,
	output logic signed [dss_pkg::SPD_W-1:0] speed_demand,
	output logic [15:0] current_limit,
	output logic contactor_on,
	output logic drive_enable,
	output logic fast_stop_active,
	output logic stop_timed_out
);
	import dss_pkg::*;

	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] mag_of(input logic signed [SPD_W-1:0] v);
		mag_of = v[SPD_W-1] ? 16'(-v) : 16'(v);
	endfunction

	// Times above 1048.5 s wrap; the settings never go that far.
	function automatic logic [MS_W-1:0] tenths_to_ms(input logic [TIME_W-1:0] t);
		tenths_to_ms = MS_W'(MS_W'(t) * MS_PER_TENTH);
	endfunction

	dss_state_e state;
	dss_state_e next_state;
	logic [TW-1:0] tick_cnt;
	logic tick;
	logic fs_latched;
	logic fast_req;
	logic [15:0] fb_mag;
	logic [15:0] sp_mag;
	logic at_zero;
	logic split_hi;
	logic stop_exp;
	logic hold_exp;
	logic enter_stop;
	logic enter_fstop;
	logic enter_hold;
	logic from_run;
	logic [MS_W-1:0] stop_ms;
	logic [MS_W-1:0] ramp_ms;
	logic div_done;
	logic [ACC_W-1:0] div_q;
	logic [ACC_W-1:0] step;
	logic step_ok;
	logic ramp_go;
	logic [ACC_W-1:0] ramp_mag;
	logic ramp_neg;
	logic [15:0] start_hi;
	logic [15:0] ramp_hi;
	logic [15:0] coast_floor;
	logic [15:0] stop_mag;
	logic signed [SPD_W-1:0] next_demand;

	// Magnitudes drive every threshold comparison.
	assign fb_mag = mag_of(speed_feedback);
	assign sp_mag = mag_of(speed_setpoint);
	assign at_zero = fb_mag <= cfg.stopped_speed_threshold;
	assign split_hi = cfg.stopped_speed_threshold > ENABLE_SPLIT_THR;
	assign fast_req = !fast_stop_input_terminal || fs_latched;

	// ------------------------------------------------------------------
	// Millisecond time base
	// ------------------------------------------------------------------

	// Free-running divider that pulses tick once per millisecond.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end
		else if (tick_cnt == TW'(TICK_CYCLES - 1))
		begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 1'b1;
			tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Fast stop latch
	// ------------------------------------------------------------------

	// Hold the request until the drive is off and the input is back high.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			fs_latched <= 1'b0;
		else if (!fast_stop_input_terminal && state != S_OFF)
			fs_latched <= 1'b1;
		else if (state == S_OFF && fast_stop_input_terminal)
			fs_latched <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------

	// Next state; fast stop outranks every normal stop step.
	always_comb
	begin
		next_state = state;
		case (state)
			S_OFF:
				if (run_input_terminal && fast_stop_input_terminal && !fs_latched)
					next_state = S_RUN;
			S_RUN:
				if (fast_req)
					next_state = S_FSTOP;
				else if (!run_input_terminal)
					next_state = S_NSTOP;
			S_NSTOP:
				if (fast_req)
					next_state = S_FSTOP;
				else if (at_zero)
					next_state = enable_input_terminal ? S_HOLD : S_OFF;
				else if (stop_exp)
					next_state = S_OFF;
			S_HOLD:
				if (!enable_input_terminal || hold_exp || fast_req)
					next_state = S_OFF;
			S_FSTOP:
				if (at_zero || stop_exp)
					next_state = S_OFF;
			default:
				next_state = S_OFF;
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			state <= S_OFF;
		else
			state <= next_state;
	end

	assign enter_fstop = (next_state == S_FSTOP) && (state != S_FSTOP);
	assign enter_stop = enter_fstop || ((next_state == S_NSTOP) && (state != S_NSTOP));
	assign enter_hold = (next_state == S_HOLD) && (state != S_HOLD);
	assign from_run = enter_stop && (state == S_RUN);

	// ------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------

	// Both stop kinds share one timeout timer, reloaded by the fast stop.
	assign stop_ms = enter_fstop ? tenths_to_ms(cfg.fast_stop_timeout) :
		tenths_to_ms(cfg.normal_stop_timeout);
	assign ramp_ms = enter_fstop ? tenths_to_ms(cfg.fast_stop_ramp_duration) :
		tenths_to_ms(cfg.normal_ramp_duration);

	dss_timer #(
		.W(MS_W)
	) u_stop_timer (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.load(enter_stop),
		.clear(state == S_OFF),
		.tick(tick),
		.load_value(stop_ms),
		.expired(stop_exp)
	);

	dss_timer #(
		.W(MS_W)
	) u_hold_timer (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.load(enter_hold),
		.clear(state == S_OFF),
		.tick(tick),
		.load_value(tenths_to_ms(cfg.main_relay_hold_time)),
		.expired(hold_exp)
	);

	// ------------------------------------------------------------------
	// Ramp
	// ------------------------------------------------------------------

	// Step per millisecond is full scale, with fraction bits, over the duration.
	dss_divider #(
		.N(ACC_W),
		.D(MS_W)
	) u_step_div (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.start(enter_stop),
		.dividend({FULL_SCALE, FRAC_ZERO}),
		.divisor(ramp_ms),
		.done(div_done),
		.quotient(div_q)
	);

	// Capture the step; the ramp waits while a new one is being formed.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			step <= '0;
			step_ok <= 1'b0;
		end
		else if (enter_stop)
			step_ok <= 1'b0;
		else if (div_done)
		begin
			step <= div_q;
			step_ok <= 1'b1;
		end
	end

	assign ramp_go = tick && step_ok && !enter_stop && (state == S_NSTOP || state == S_FSTOP);

	// Start from the setpoint, then walk the magnitude down to zero linearly.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ramp_mag <= '0;
			ramp_neg <= 1'b0;
			start_hi <= '0;
		end
		else if (from_run)
		begin
			ramp_mag <= {sp_mag, FRAC_ZERO};
			ramp_neg <= speed_setpoint[SPD_W-1];
			start_hi <= sp_mag;
		end
		else if (ramp_go)
			ramp_mag <= (ramp_mag > step) ? ramp_mag - step : '0;
	end

	// Without regeneration the demand may not fall below what coasting gives.
	assign ramp_hi = ramp_mag[ACC_W-1:FRAC_W];
	assign coast_floor = (fb_mag < start_hi) ? fb_mag : start_hi;
	assign stop_mag = (cfg.regen || ramp_hi > coast_floor) ? ramp_hi : coast_floor;

	// Demand follows the setpoint while running and the ramp while stopping.
	always_comb
	begin
		case (state)
			S_RUN:
				next_demand = speed_setpoint;
			S_NSTOP, S_FSTOP:
				next_demand = ramp_neg ? SPD_W'(-stop_mag) : SPD_W'(stop_mag);
			default:
				next_demand = '0;
		endcase
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// Speed demand to the speed loop.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			speed_demand <= '0;
		else
			speed_demand <= next_demand;
	end

	// Contactor, enable and current cap follow the state being entered.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			contactor_on <= 1'b0;
			drive_enable <= 1'b0;
			current_limit <= CUR_LIMIT_OPEN;
			fast_stop_active <= 1'b0;
		end
		else
		begin
			contactor_on <= (next_state != S_OFF);
			drive_enable <= (next_state == S_RUN) || (next_state == S_NSTOP) ||
				(next_state == S_FSTOP) || (next_state == S_HOLD && !split_hi);
			current_limit <= (next_state == S_FSTOP) ? cfg.fast_stop_current_cap :
				CUR_LIMIT_OPEN;
			fast_stop_active <= (next_state == S_FSTOP);
		end
	end

	// Flags a coast stop forced by a timeout until the next run.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			stop_timed_out <= 1'b0;
		else if ((state == S_NSTOP || state == S_FSTOP) && next_state == S_OFF && !at_zero)
			stop_timed_out <= 1'b1;
		else if (next_state == S_RUN)
			stop_timed_out <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	chk_run_starts_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_RUN && !run_input_terminal && !fast_req |=> state == S_NSTOP && contactor_on)
		else $error("run removal did not start a normal stop");
	chk_off_drops_all: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_OFF |-> !contactor_on && !drive_enable)
		else $error("contactor or enable on while off");
	chk_timeout_coasts: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_NSTOP && !fast_req && !at_zero && stop_exp |=> state == S_OFF && stop_timed_out)
		else $error("normal stop timeout did not coast");
	chk_hold_keeps_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_NSTOP && !fast_req && at_zero && enable_input_terminal
		|=> state == S_HOLD && contactor_on)
		else $error("contactor not held after reaching threshold");
	chk_hold_enable_split: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_HOLD && $stable(cfg.stopped_speed_threshold) |-> drive_enable == !split_hi)
		else $error("enable wrong during contactor hold");
	chk_hold_bypass: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_HOLD && !enable_input_terminal |=> state == S_OFF ##0 !contactor_on)
		else $error("hold not bypassed with enable low");
	chk_fast_stop_entry: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_RUN && !fast_stop_input_terminal |=> state == S_FSTOP && fast_stop_active)
		else $error("fast stop not started");
	chk_fast_zero_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_FSTOP && at_zero |=> !contactor_on && !drive_enable)
		else $error("fast stop at threshold left drive on");
	chk_fast_timeout: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_FSTOP && stop_exp && !at_zero |=> state == S_OFF && stop_timed_out)
		else $error("fast stop timeout not honoured");
	chk_fast_cap: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_FSTOP && $stable(cfg.fast_stop_current_cap)
		|-> current_limit == cfg.fast_stop_current_cap)
		else $error("current cap missing during fast stop");
	chk_fast_latched: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == S_FSTOP && !at_zero && !stop_exp |=> state == S_FSTOP)
		else $error("fast stop abandoned before completion");
	chk_ramp_falls: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ramp_go |=> ramp_mag <= $past(ramp_mag) && (ramp_mag == '0 || ramp_mag == $past(ramp_mag) - step))
		else $error("ramp did not step down linearly");
endmodule // dss_stop_sequencer
`default_nettype wire

// >>> src/dss_timer.sv
// Millisecond down counter used for the stop timeout and the contactor hold.
// Assumes a one-cycle tick pulse once per millisecond.
`timescale 1ns/100ps
`default_nettype none
module dss_timer #(
	parameter int W = 20
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic load,
	input wire logic clear,
	input wire logic tick,
	input wire logic [W-1:0] load_value,
	output logic expired
);
	logic [W-1:0] count;
	logic armed;

	// Load the count, then step it down on every tick until zero.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			count <= '0;
		else if (load)
			count <= load_value;
		else if (tick && count != '0)
			count <= count - 1'b1;
	end

	// The timer only reports expiry after it has been loaded.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			armed <= 1'b0;
		else if (load)
			armed <= 1'b1;
		else if (clear)
			armed <= 1'b0;
	end

	assign expired = armed && (count == '0) && !load;
endmodule // dss_timer
`default_nettype wire

// >>> verif/dss_motor_model.sv
// Behavioural motor with contactor, speed loop and enable terminal gating.
// Assumes one clock; speed follows demand while energized and enabled.
`timescale 1ns/100ps
`default_nettype none
module dss_motor_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic signed [dss_pkg::SPD_W-1:0] speed_demand,
	input wire logic contactor_on,
	input wire logic drive_enable,
	input wire logic stall,
	input wire logic ext_enable,
	input wire logic aux_enable,
	output logic enable_input_terminal,
	output logic signed [dss_pkg::SPD_W-1:0] speed_feedback
);
	import dss_pkg::*;

	// The terminal enable is gated by the auxiliary software enable.
	assign enable_input_terminal = ext_enable & aux_enable;

	// A stalled shaft holds speed; a driven one tracks demand; otherwise it coasts down.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			speed_feedback <= 16'sh0000;
		else if (stall)
			speed_feedback <= speed_feedback;
		else if (contactor_on && drive_enable)
			speed_feedback <= speed_demand;
		else if (speed_feedback > 16'sh0032)
			speed_feedback <= speed_feedback - 16'sh0032;
		else if (speed_feedback < -16'sh0032)
			speed_feedback <= speed_feedback + 16'sh0032;
		else
			speed_feedback <= 16'sh0000;
	end
endmodule // dss_motor_model
`default_nettype wire

// >>> verif/dss_stop_sequencer_tb.sv
// Self-checking bench of the stop sequencer with a behavioural motor.
// Assumes a shortened millisecond of 20 cycles, so one tenth of a second is 2000 cycles.
`timescale 1ns/100ps
`default_nettype none
module dss_stop_sequencer_tb;
	import dss_pkg::*;

	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	localparam int TK = 20;
	logic clk_sys, arst_n, run, fast, ext_en, aux, stall, en_in, con, den, fsa, sto;
	dss_cfg_s cfg;
	logic signed [SPD_W-1:0] sp, fb, dem;
	logic [15:0] ilim;
	int num_errors = 0;
	int n_checks = 0;
	int n;

	dss_stop_sequencer #(.TICK_CYCLES(TK)) dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .cfg(cfg),
		.run_input_terminal(run), .fast_stop_input_terminal(fast),
		.enable_input_terminal(en_in), .speed_setpoint(sp), .speed_feedback(fb),
		.speed_demand(dem), .current_limit(ilim), .contactor_on(con),
		.drive_enable(den), .fast_stop_active(fsa), .stop_timed_out(sto)
	);

	dss_motor_model motor (
		.clk_sys(clk_sys), .arst_n(arst_n), .speed_demand(dem), .contactor_on(con),
		.drive_enable(den), .stall(stall), .ext_enable(ext_en), .aux_enable(aux),
		.enable_input_terminal(en_in), .speed_feedback(fb)
	);

	// ------------------------------------------------------------------
	// Compare, wait and closing tasks
	// ------------------------------------------------------------------
	task automatic check_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic check_range(input string nm, input int lo, input int hi,
		input logic signed [31:0] g);
		n_checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			num_errors++;
			$display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// Moves k edges on and leaves the outputs settled.
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// Counts cycles until the contactor (sel 0) or the drive enable (sel 1) is low.
	task automatic wait_low(input bit sel, output int cnt);
		cnt = 0;
		do
		begin
			cyc(1);
			cnt++;
		end
		while ((sel ? den : con) !== 1'b0 && cnt < 20000);
	endtask

	// Starts the drive at a setpoint and lets the motor follow it.
	task automatic start(input logic signed [15:0] s);
		@(posedge clk_sys);
		sp <= s;
		run <= 1'b1;
		fast <= 1'b1;
		ext_en <= 1'b1;
		aux <= 1'b1;
		cyc(40);
		check_bit("contactor_on", 1'b1, con);
		check_bit("drive_enable", 1'b1, den);
		check_bit("stop_timed_out", 1'b0, sto);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Cuts a hang short well past the expected run of about 21000 cycles.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end

	initial
	begin
		arst_n = 1'b0;
		run = 1'b0;
		fast = 1'b1;
		ext_en = 1'b1;
		aux = 1'b1;
		stall = 1'b0;
		sp = 16'sh0000;
		cfg = '{regen: 1'b1, normal_ramp_duration: 16'h0001, normal_stop_timeout: 16'h0003,
			main_relay_hold_time: 16'h0001, fast_stop_ramp_duration: FAST_RAMP_DEF,
			fast_stop_timeout: 16'h0003, stopped_speed_threshold: STOPPED_THR_DEF,
			fast_stop_current_cap: 16'h1388};
		cyc(12);
		check_val("speed_demand", 16'h0000, dem);
		check_val("current_limit", CUR_LIMIT_OPEN, ilim);
		check_bit("contactor_on", 1'b0, con);
		check_bit("fast_stop_active", 1'b0, fsa);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		// Normal stop, threshold above the split: enable drops when the hold starts.
		start(16'sh2710);
		@(posedge clk_sys);
		run <= 1'b0;
		cyc(1033);
		check_range("speed_demand", 4800, 5200, dem);
		wait_low(1'b1, n);
		check_bit("contactor_on", 1'b1, con);
		check_range("ramp_cycles", 930, 1030, n);
		wait_low(1'b0, n);
		check_range("hold_cycles", 1975, 2030, n);
		check_bit("drive_enable", 1'b0, den);
		// Negative speed, low threshold: enable stays on through the hold.
		@(posedge clk_sys);
		cfg.stopped_speed_threshold <= 16'h0014;
		start(-16'sh2710);
		@(posedge clk_sys);
		run <= 1'b0;
		cyc(1033);
		check_range("speed_demand", -5200, -4800, dem);
		wait_low(1'b1, n);
		check_bit("contactor_on", 1'b0, con);
		check_range("stop_hold_cycles", 2960, 3080, n);
		// A low enable terminal skips the contactor hold.
		@(posedge clk_sys);
		cfg.stopped_speed_threshold <= STOPPED_THR_DEF;
		start(16'sh2710);
		@(posedge clk_sys);
		run <= 1'b0;
		ext_en <= 1'b0;
		wait_low(1'b0, n);
		check_range("stop_cycles", 1950, 2080, n);
		check_bit("drive_enable", 1'b0, den);
		// Dropping the auxiliary enable during the hold releases the contactor at once.
		start(16'sh2710);
		@(posedge clk_sys);
		run <= 1'b0;
		wait_low(1'b1, n);
		check_bit("contactor_on", 1'b1, con);
		@(posedge clk_sys);
		aux <= 1'b0;
		wait_low(1'b0, n);
		check_range("bypass_cycles", 1, 2, n);
		// Stalled motor, non-regenerative: demand holds at speed, then timeout coasts.
		@(posedge clk_sys);
		cfg.regen <= 1'b0;
		cfg.normal_stop_timeout <= 16'h0001;
		start(16'sh2710);
		@(posedge clk_sys);
		run <= 1'b0;
		stall <= 1'b1;
		cyc(1000);
		check_val("speed_demand", 16'h2710, dem);
		wait_low(1'b0, n);
		check_range("timeout_cycles", 960, 1040, n);
		check_bit("drive_enable", 1'b0, den);
		check_bit("stop_timed_out", 1'b1, sto);
		@(posedge clk_sys);
		stall <= 1'b0;
		cfg.regen <= 1'b1;
		cfg.normal_stop_timeout <= 16'h0003;
		cyc(300);
		// Fast stop from a one-cycle request runs to completion with the current cap.
		start(16'sh2710);
		@(posedge clk_sys);
		fast <= 1'b0;
		@(posedge clk_sys);
		fast <= 1'b1;
		cyc(5);
		check_bit("fast_stop_active", 1'b1, fsa);
		check_val("current_limit", 16'h1388, ilim);
		wait_low(1'b1, n);
		check_bit("contactor_on", 1'b0, con);
		check_range("fast_cycles", 1940, 2060, n);
		check_val("current_limit", CUR_LIMIT_OPEN, ilim);
		// A fast stop during a normal stop goes on from the ramp value, with no hold.
		start(16'sh2710);
		@(posedge clk_sys);
		run <= 1'b0;
		cyc(500);
		@(posedge clk_sys);
		fast <= 1'b0;
		@(posedge clk_sys);
		fast <= 1'b1;
		cyc(5);
		check_range("speed_demand", 7500, 7800, dem);
		check_val("current_limit", 16'h1388, ilim);
		wait_low(1'b1, n);
		check_bit("contactor_on", 1'b0, con);
		check_range("nstop_fast_cycles", 1470, 1550, n);
		check_bit("stop_timed_out", 1'b0, sto);
		// Stalled fast stop ends at its own timeout.
		@(posedge clk_sys);
		cfg.fast_stop_timeout <= 16'h0001;
		start(16'sh2710);
		@(posedge clk_sys);
		fast <= 1'b0;
		stall <= 1'b1;
		@(posedge clk_sys);
		fast <= 1'b1;
		wait_low(1'b0, n);
		check_range("fast_timeout_cycles", 1970, 2040, n);
		check_bit("drive_enable", 1'b0, den);
		check_bit("stop_timed_out", 1'b1, sto);
		conclude();
	end
endmodule // dss_stop_sequencer_tb
`default_nettype wire
